// [logic/sas_pkg.sv]
`default_nettype none
// ----------------------------------------------------------------
// Converter sequencer constants
// ----------------------------------------------------------------
package sas_pkg;
   localparam int AW = 4;
   localparam int DW = 16;
   localparam int RES_BITS = 12;
   localparam int NUM_INPUTS = 16;
   localparam int CNT_W = 5;

   // Register offsets
   localparam logic [AW-1:0] OFF_CONTROL_ONE   = 4'h0;
   localparam logic [AW-1:0] OFF_CONTROL_TWO   = 4'h1;
   localparam logic [AW-1:0] OFF_CONTROL_THREE = 4'h2;
   localparam logic [AW-1:0] OFF_CHAN_SELECT   = 4'h3;
   localparam logic [AW-1:0] OFF_PIN_CONFIG    = 4'h4;
   localparam logic [AW-1:0] OFF_SCAN_SELECT   = 4'h5;
   localparam logic [AW-1:0] OFF_RESULT        = 4'h6;
   localparam logic [AW-1:0] OFF_IRQ_STATUS    = 4'h7;
   localparam logic [AW-1:0] OFF_IRQ_MASK      = 4'h8;

   // Field positions
   localparam int POS_ENABLE   = 15;
   localparam int POS_TRIG_LO  = 5;
   localparam int POS_AUTO_SMP = 2;
   localparam int POS_SAMPLE   = 1;
   localparam int POS_DONE     = 0;
   localparam int POS_REF_EXT  = 13;
   localparam int POS_SPI_LO   = 2;
   localparam int POS_BUF_MODE = 1;
   localparam int POS_ALT_IN   = 0;
   localparam int POS_SMP_CNT  = 8;
   localparam int POS_RC_SEL   = 7;
   localparam int POS_DIV_LO   = 0;
   localparam int POS_CH_A     = 0;
   localparam int POS_CH_B     = 8;
   localparam int IRQ_DONE     = 0;
   localparam int IRQ_ABORT    = 1;

   // Values after reset
   localparam logic [DW-1:0] RST_REG = 16'h0000;
   localparam logic [RES_BITS-1:0] RST_RESULT = 12'h000;

   // Trigger source codes
   localparam logic [2:0] TRIG_SOFTWARE = 3'h0;
   localparam logic [2:0] TRIG_EXT_INT  = 3'h1;
   localparam logic [2:0] TRIG_TIMER_A  = 3'h2;
   localparam logic [2:0] TRIG_TIMER_B  = 3'h3;
   localparam logic [2:0] TRIG_AUTO     = 3'h7;

   // Counts of conversion clock periods
   localparam logic [CNT_W-1:0] CONV_TADS     = 5'h0e;
   localparam logic [CNT_W-1:0] SW_DELAY_TADS = 5'h0b;

   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_DELAY, ST_CONVERT} sas_state_t;
endpackage
`default_nettype wire

// [logic/sas_sequencer.sv]
// Notes on behaviour
// - Successive approximation turns the selected input into a 12-bit result.
// - Up to 16 inputs share one multiplexer and one sample-and-hold.
// - A control bit picks supply pair or external reference pins.
// - Conversion continues in sleep when the RC clock is selected.
// - Separate registers hold channel select, pin analog/digital, scan inputs.
// - A trigger ends acquisition and starts conversion.
// - Software source: clearing sample bit triggers after 11 conversion clocks.
// - Auto source: trigger after programmed conversion clocks of acquisition.
// - Three-bit source field picks software, auto, timers or external interrupt.
// - Clearing enable aborts conversion and halts sampling until enable is set again with the sample bit or auto sample.
// - Aborted conversion leaves result buffer holding last written value; a disable on the final period still writes the result.
// - Disable in same cycle as auto trigger wins; no conversion starts.
// - Each conversion takes 14 conversion clock periods.
// - Conversion clock is half instruction cycle times divider plus one.
// - RC select bit clocks the converter from the RC oscillator.
`timescale 1ns/100ps
`default_nettype none
module sas_sequencer
   import sas_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     rstn,
   input  wire logic [sas_pkg::AW-1:0]   reg_addr,
   input  wire logic [sas_pkg::DW-1:0]   reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic      [sas_pkg::DW-1:0]   reg_rdata,
   input  wire logic                     sleep_mode,
   input  wire logic                     rc_osc_pin,
   input  wire logic                     ext_int_pin,
   input  wire logic                     timer_a_trig,
   input  wire logic                     timer_b_trig,
   input  wire logic                     cmp_in,
   output logic      [3:0]               mux_channel,
   output logic                          sample_hold,
   output logic      [sas_pkg::RES_BITS-1:0] dac_code,
   output logic                          ref_external,
   output logic      [sas_pkg::NUM_INPUTS-1:0] pin_analog,
   output logic      [sas_pkg::NUM_INPUTS-1:0] scan_inputs,
   output logic                          irq
);
   import sas_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [DW-1:0]       adc_control_one;
   logic [DW-1:0]       adc_control_two;
   logic [DW-1:0]       adc_control_three;
   logic [DW-1:0]       input_channel_select;
   logic [DW-1:0]       pin_analog_digital_config;
   logic [DW-1:0]       scan_input_select;
   logic [RES_BITS-1:0] result_buffer;
   logic [1:0]          irq_status;
   logic [1:0]          irq_mask;
   sas_state_t          state;
   sas_state_t          next_state;
   logic [CNT_W-1:0]    tad_cnt;
   logic [5:0]          div_cnt;
   logic [RES_BITS-1:0] sar;
   logic [3:0]          smp_cnt;
   logic [2:0]          rc_sync;
   logic [2:0]          ext_sync;
   logic [2:0]          cmp_sync;
   logic                rc_lvl;
   logic                rc_lvl_d;
   logic                ext_lvl;
   logic                ext_lvl_d;
   logic                cmp_lvl;
   logic                enter_conv;

   // ----------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------
   wire        enable        = adc_control_one[POS_ENABLE];
   wire [2:0]  trigger_source_sel = adc_control_one[POS_TRIG_LO +: 3];
   wire        auto_sample_enable = adc_control_one[POS_AUTO_SMP];
   wire        sample_control = adc_control_one[POS_SAMPLE];
   wire [3:0]  samples_per_interrupt = adc_control_two[POS_SPI_LO +: 4];
   wire        alternate_input_sel = adc_control_two[POS_ALT_IN];
   wire [4:0]  auto_sample_count = adc_control_three[POS_SMP_CNT +: 5];
   wire        rc_clock_select = adc_control_three[POS_RC_SEL];
   wire [5:0]  conv_clock_divider = adc_control_three[POS_DIV_LO +: 6];

   // Bus strobes per register
   wire wr_one   = reg_wr && (reg_addr == OFF_CONTROL_ONE);
   wire wr_two   = reg_wr && (reg_addr == OFF_CONTROL_TWO);
   wire wr_three = reg_wr && (reg_addr == OFF_CONTROL_THREE);
   wire wr_chan  = reg_wr && (reg_addr == OFF_CHAN_SELECT);
   wire wr_pin   = reg_wr && (reg_addr == OFF_PIN_CONFIG);
   wire wr_scan  = reg_wr && (reg_addr == OFF_SCAN_SELECT);
   wire wr_res   = reg_wr && (reg_addr == OFF_RESULT);
   wire wr_ist   = reg_wr && (reg_addr == OFF_IRQ_STATUS);
   wire wr_imsk  = reg_wr && (reg_addr == OFF_IRQ_MASK);

   // Disable seen this cycle, including a write that clears it
   wire kill = wr_one ? !reg_wdata[POS_ENABLE] : !enable;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Three stages; level moves only when stages two and three agree
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rc_sync  <= 3'h0;
         ext_sync <= 3'h0;
         cmp_sync <= 3'h0;
      end
      else
      begin
         rc_sync  <= {rc_sync[1:0], rc_osc_pin};
         ext_sync <= {ext_sync[1:0], ext_int_pin};
         cmp_sync <= {cmp_sync[1:0], cmp_in};
      end
   end

   // Filtered levels and edge history
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rc_lvl    <= 1'b0;
         ext_lvl   <= 1'b0;
         cmp_lvl   <= 1'b0;
         rc_lvl_d  <= 1'b0;
         ext_lvl_d <= 1'b0;
      end
      else
      begin
         if (rc_sync[1] == rc_sync[2])
            rc_lvl <= rc_sync[2];
         if (ext_sync[1] == ext_sync[2])
            ext_lvl <= ext_sync[2];
         if (cmp_sync[1] == cmp_sync[2])
            cmp_lvl <= cmp_sync[2];
         rc_lvl_d  <= rc_lvl;
         ext_lvl_d <= ext_lvl;
      end
   end

   // ----------------------------------------------------------------
   // Conversion clock
   // ----------------------------------------------------------------
   // Divider counts half instruction cycles; halts while asleep
   // Restarts when a conversion begins so the first step settles a full period
   wire div_tick = !sleep_mode && (div_cnt == conv_clock_divider);
   wire rc_tick  = rc_lvl && !rc_lvl_d;
   wire conv_clock_period      = rc_clock_select ? rc_tick : div_tick;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         div_cnt <= 6'h00;
      else if (div_tick || !enable || enter_conv)
         div_cnt <= 6'h00;
      else if (!sleep_mode)
         div_cnt <= div_cnt + 6'h01;
   end

   // ----------------------------------------------------------------
   // Trigger selection
   // ----------------------------------------------------------------
   wire ext_rise  = ext_lvl && !ext_lvl_d;
   wire [4:0] smp_min = (auto_sample_count == 5'h00) ? 5'h01 : auto_sample_count;
   wire auto_fire = conv_clock_period && (tad_cnt + 5'h01 >= smp_min);
   wire src_fire  = (trigger_source_sel == TRIG_EXT_INT) ? ext_rise :
                    (trigger_source_sel == TRIG_TIMER_A) ? timer_a_trig :
                    (trigger_source_sel == TRIG_TIMER_B) ? timer_b_trig :
                    (trigger_source_sel == TRIG_AUTO)    ? auto_fire : 1'b0;
   wire sw_mode   = (trigger_source_sel == TRIG_SOFTWARE);
   wire sw_fire   = conv_clock_period && (tad_cnt == SW_DELAY_TADS - 5'h01);
   wire conv_done = (state == ST_CONVERT) && conv_clock_period && (tad_cnt == CONV_TADS - 5'h01);
   wire start_smp = enable && (sample_control || auto_sample_enable);

   // ----------------------------------------------------------------
   // Successive approximation step
   // ----------------------------------------------------------------
   wire [RES_BITS-1:0] trial    = 12'h800 >> tad_cnt[3:0];
   wire [RES_BITS-1:0] next_sar = ((cmp_lvl || tad_cnt >= 5'h0c) ? sar : (sar & ~trial)) | (trial >> 1);

   // ----------------------------------------------------------------
   // Sequencer state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
            if (start_smp && !kill)
               next_state = ST_SAMPLE;
         ST_SAMPLE:
            if (kill)
               next_state = ST_IDLE;
            else if (sw_mode && !sample_control)
               next_state = ST_DELAY;
            else if (!sw_mode && src_fire)
               next_state = ST_CONVERT;
         ST_DELAY:
            if (kill)
               next_state = ST_IDLE;
            else if (sw_fire)
               next_state = ST_CONVERT;
         ST_CONVERT:
            if (kill)
               next_state = ST_IDLE;
            else if (conv_done)
               next_state = auto_sample_enable ? ST_SAMPLE : ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
   end

   assign enter_conv = (state != ST_CONVERT) && (next_state == ST_CONVERT);
   wire aborted    = kill && (state == ST_CONVERT || state == ST_DELAY);

   // State, period counter and approximation register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state   <= ST_IDLE;
         tad_cnt <= 5'h00;
         sar     <= 12'h000;
      end
      else
      begin
         state <= next_state;
         if (next_state != state)
            tad_cnt <= 5'h00;
         else if (conv_clock_period)
            tad_cnt <= tad_cnt + 5'h01;
         if (enter_conv)
            sar <= 12'h800;
         else if (state == ST_CONVERT && conv_clock_period)
            sar <= next_sar;
      end
   end

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   // First control register: sample bit and done flag also moved by hardware
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         adc_control_one <= RST_REG;
      else
      begin
         if (wr_one)
            adc_control_one <= reg_wdata;
         if (kill && state != ST_IDLE)
            adc_control_one[POS_SAMPLE] <= 1'b0;
         else if (enter_conv && !sw_mode)
            adc_control_one[POS_SAMPLE] <= 1'b0;
         else if (conv_done && auto_sample_enable)
            adc_control_one[POS_SAMPLE] <= 1'b1;
         if (conv_done)
            adc_control_one[POS_DONE] <= 1'b1;
      end
   end

   // Plain configuration registers
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         adc_control_two           <= RST_REG;
         adc_control_three         <= RST_REG;
         input_channel_select      <= RST_REG;
         pin_analog_digital_config <= RST_REG;
         scan_input_select         <= RST_REG;
         irq_mask                  <= 2'h0;
      end
      else
      begin
         if (wr_two)
            adc_control_two <= reg_wdata;
         if (wr_three)
            adc_control_three <= reg_wdata;
         if (wr_chan)
            input_channel_select <= reg_wdata;
         if (wr_pin)
            pin_analog_digital_config <= reg_wdata;
         if (wr_scan)
            scan_input_select <= reg_wdata;
         if (wr_imsk)
            irq_mask <= reg_wdata[1:0];
      end
   end

   // Result buffer, status and samples per interrupt
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         result_buffer <= RST_RESULT;
         irq_status    <= 2'h0;
         smp_cnt       <= 4'h0;
      end
      else
      begin
         if (conv_done)
            result_buffer <= next_sar;
         else if (wr_res)
            result_buffer <= reg_wdata[RES_BITS-1:0];
         if (conv_done)
            smp_cnt <= (smp_cnt == samples_per_interrupt) ? 4'h0 : smp_cnt + 4'h1;
         irq_status[IRQ_DONE] <= (conv_done && smp_cnt == samples_per_interrupt) ||
                                 (irq_status[IRQ_DONE] && !(wr_ist && reg_wdata[IRQ_DONE]));
         irq_status[IRQ_ABORT] <= aborted ||
                                  (irq_status[IRQ_ABORT] && !(wr_ist && reg_wdata[IRQ_ABORT]));
      end
   end

   // Read data one cycle after the strobe; unmapped reads zero
   wire [DW-1:0] rd_mux =
      (reg_addr == OFF_CONTROL_ONE)   ? adc_control_one :
      (reg_addr == OFF_CONTROL_TWO)   ? adc_control_two :
      (reg_addr == OFF_CONTROL_THREE) ? adc_control_three :
      (reg_addr == OFF_CHAN_SELECT)   ? input_channel_select :
      (reg_addr == OFF_PIN_CONFIG)    ? pin_analog_digital_config :
      (reg_addr == OFF_SCAN_SELECT)   ? scan_input_select :
      (reg_addr == OFF_RESULT)        ? {4'h0, result_buffer} :
      (reg_addr == OFF_IRQ_STATUS)    ? {14'h0000, irq_status} :
      (reg_addr == OFF_IRQ_MASK)      ? {14'h0000, irq_mask} : 16'h0000;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         reg_rdata <= 16'h0000;
      else
         reg_rdata <= reg_rd ? rd_mux : 16'h0000;
   end

   // ----------------------------------------------------------------
   // Front end outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mux_channel  <= 4'h0;
         sample_hold  <= 1'b0;
         ref_external <= 1'b0;
         pin_analog   <= 16'h0000;
         scan_inputs  <= 16'h0000;
      end
      else
      begin
         mux_channel  <= alternate_input_sel ? input_channel_select[POS_CH_B +: 4] :
                                               input_channel_select[POS_CH_A +: 4];
         sample_hold  <= (next_state == ST_SAMPLE);
         ref_external <= adc_control_two[POS_REF_EXT];
         pin_analog   <= ~pin_analog_digital_config;
         scan_inputs  <= scan_input_select;
      end
   end

   assign dac_code = sar;
   assign irq      = |(irq_status & irq_mask);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   logic [4:0] chk_tads;
   logic [6:0] chk_gap;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         chk_tads <= 5'h00;
         chk_gap  <= 7'h00;
      end
      else
      begin
         chk_tads <= enter_conv ? 5'h00 : (state == ST_CONVERT && conv_clock_period) ? chk_tads + 5'h01 : chk_tads;
         chk_gap  <= (div_tick || !enable || enter_conv) ? 7'h00 : sleep_mode ? chk_gap : chk_gap + 7'h01;
      end
   end

   sequence s_abort_req;
      kill && state != ST_IDLE;
   endsequence
   sequence s_halted;
      state == ST_IDLE && !sample_hold;
   endsequence

   property p_conv_len;
      conv_done && !kill |-> chk_tads == 5'h0d;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion not 14 periods");

   property p_abort;
      s_abort_req |=> s_halted;
   endproperty
   a_abort: assert property (p_abort) else $error("abort did not halt");

   property p_no_partial;
      !$past(conv_done) && !$past(wr_res) |-> $stable(result_buffer);
   endproperty
   a_no_partial: assert property (p_no_partial) else $error("result changed without cause");

   property p_disable_wins;
      state == ST_SAMPLE && auto_fire && kill |=> state != ST_CONVERT [*2];
   endproperty
   a_disable_wins: assert property (p_disable_wins) else $error("conversion started on disable");

   property p_sw_delay;
      state == ST_DELAY && sw_fire && !kill |=> state == ST_CONVERT && tad_cnt == 5'h00;
   endproperty
   a_sw_delay: assert property (p_sw_delay) else $error("software delay wrong");

   property p_div;
      div_tick && $past(enable) && !$past(div_tick) |-> chk_gap == {1'b0, conv_clock_divider};
   endproperty
   a_div: assert property (p_div) else $error("divider period wrong");

   property p_clock_src;
      (rc_clock_select && !rc_tick) || (!rc_clock_select && sleep_mode) |-> !conv_clock_period;
   endproperty
   a_clock_src: assert property (p_clock_src) else $error("wrong conversion clock");

   property p_done;
      conv_done && !kill |=> adc_control_one[POS_DONE] && result_buffer == $past(next_sar);
   endproperty
   a_done: assert property (p_done) else $error("completion not recorded");

   property p_trigger;
      state == ST_SAMPLE && !sw_mode && src_fire && !kill |=> state == ST_CONVERT ##1 !sample_hold;
   endproperty
   a_trigger: assert property (p_trigger) else $error("trigger did not start conversion");

   property p_ref;
      wr_two |=> ##1 ref_external == $past(reg_wdata[POS_REF_EXT], 2);
   endproperty
   a_ref: assert property (p_ref) else $error("reference select not applied");
endmodule
`default_nettype wire

// [verification/sas_afe_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Analog front end: multiplexer, hold stage, comparator
// ----------------------------------------------------------------
module sas_afe_model
   import sas_pkg::*;
(
   input  wire logic                                              clk,
   input  wire logic                                              rstn,
   input  wire logic [3:0]                                        mux_channel,
   input  wire logic                                              sample_hold,
   input  wire logic [sas_pkg::RES_BITS-1:0]                      dac_code,
   input  wire logic [sas_pkg::NUM_INPUTS-1:0][sas_pkg::RES_BITS-1:0] level,
   output logic                                                   cmp_in
);
   import sas_pkg::*;

   logic [RES_BITS-1:0] held;
   // Track the selected input while acquiring, keep it once released
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         held <= '0;
      else if (sample_hold)
         held <= level[mux_channel];
   end
   // Ideal comparator against the trial word
   assign cmp_in = (held >= dac_code);
endmodule
`default_nettype wire

// [verification/tb_sas_sequencer.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Sequencer bench
// ----------------------------------------------------------------
module tb_sas_sequencer;
   import sas_pkg::*;
   logic                                clk, rstn, reg_wr, reg_rd, sleep_mode, rc_osc_pin, rc_run, cmp_in;
   logic                                ext_int_pin, timer_a_trig, timer_b_trig, sample_hold, ref_external, irq;
   logic [AW-1:0]                       reg_addr;
   logic [DW-1:0]                       reg_wdata, reg_rdata, d, r;
   logic [3:0]                          mux_channel;
   logic [2:0]                          rc_div;
   logic [RES_BITS-1:0]                 dac_code;
   logic [NUM_INPUTS-1:0]               pin_analog, scan_inputs;
   logic [NUM_INPUTS-1:0][RES_BITS-1:0] level;
   logic [RES_BITS-1:0]                 exp_q [$];
   logic [2:0]                          src_tab [5] = '{3'h0, 3'h7, 3'h1, 3'h2, 3'h3};
   int                                  lo_tab [5] = '{235, 135, 125, 125, 125};
   int                                  hi_tab [5] = '{260, 175, 160, 160, 160};
   int                                  seed = 32'hd7c8;
   int                                  fail_count = 0;
   int                                  checks = 0;

   sas_sequencer u_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
      .rc_osc_pin(rc_osc_pin), .ext_int_pin(ext_int_pin), .timer_a_trig(timer_a_trig),
      .timer_b_trig(timer_b_trig), .cmp_in(cmp_in), .mux_channel(mux_channel), .sample_hold(sample_hold),
      .dac_code(dac_code), .ref_external(ref_external), .pin_analog(pin_analog),
      .scan_inputs(scan_inputs), .irq(irq));
   sas_afe_model u_afe (.clk(clk), .rstn(rstn), .mux_channel(mux_channel), .sample_hold(sample_hold),
      .dac_code(dac_code), .level(level), .cmp_in(cmp_in));

   // Clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // RC oscillator, eight clocks a period while running
   always @(posedge clk)
   begin
      rc_div <= rc_div + 3'h1;
      rc_osc_pin <= rc_run & rc_div[2];
   end

   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_n(input int got, input int lo, input int hi);
      checks++;
      if (got < lo || got > hi)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: %0d cycles outside %0d..%0d", $time, got, lo, hi);
      end
   endtask
   task automatic fire(input logic [2:0] src);
      @(posedge clk);
      ext_int_pin <= (src == TRIG_EXT_INT);
      timer_a_trig <= (src == TRIG_TIMER_A);
      timer_b_trig <= (src == TRIG_TIMER_B);
      @(posedge clk);
      timer_a_trig <= 1'b0;
      timer_b_trig <= 1'b0;
      repeat (4) @(posedge clk);
      ext_int_pin <= 1'b0;
   endtask
   // One conversion from a random input level, timed to completion
   task automatic convert(input logic [2:0] src, input int lo, input int hi);
      logic [DW-1:0] v;
      int k;
      v = $random(seed);
      level[v[15:12]] = v[11:0];
      exp_q.push_back(v[0] ? v[11:0] : level[~v[15:12]]);
      wr(OFF_CONTROL_TWO, {3'h1, 12'h000, v[0]});
      wr(OFF_CHAN_SELECT, {4'h0, v[15:12], 4'h0, ~v[15:12]});
      wr(OFF_CONTROL_ONE, {8'h00, src, 5'h00});
      wr(OFF_CONTROL_ONE, {8'h80, src, 2'b00, src == TRIG_AUTO, src != TRIG_AUTO, 1'b0});
      if (src != TRIG_AUTO)
         repeat (40) @(posedge clk);
      if (src == TRIG_SOFTWARE)
         wr(OFF_CONTROL_ONE, 16'h8000);
      else if (src != TRIG_AUTO)
         fire(src);
      k = 0;
      while (irq !== 1'b1 && k < 2000)
      begin
         @(posedge clk);
         k++;
      end
      chk_n(k, lo, hi);
      rd(OFF_RESULT, v);
      chk(v, {4'h0, exp_q.pop_front()});
      rd(OFF_CONTROL_ONE, v);
      chk(v & 16'h0001, 16'h0001);
      wr(OFF_CONTROL_ONE, 16'h0000);
      wr(OFF_IRQ_STATUS, 16'h0003);
   endtask
   task automatic report_and_stop();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      {rstn, reg_wr, reg_rd, sleep_mode, rc_run, ext_int_pin, timer_a_trig, timer_b_trig} = '0;
      {reg_addr, reg_wdata, rc_div, rc_osc_pin} = '0;
      level = '0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      for (int a = 0; a <= 9; a++)
      begin
         rd(AW'(a), d);
         chk(d, RST_REG);
      end
      wr(4'h9, 16'hffff);
      rd(4'h9, d);
      chk(d, 16'h0000);
      r = $random(seed);
      wr(OFF_PIN_CONFIG, r);
      wr(OFF_SCAN_SELECT, r ^ 16'h5a5a);
      wr(OFF_CONTROL_TWO, 16'h2000);
      repeat (2) @(posedge clk);
      #1 chk(pin_analog, ~r);
      chk(scan_inputs, r ^ 16'h5a5a);
      chk({15'h0000, ref_external}, 16'h0001);
      wr(OFF_CONTROL_THREE, 16'h0109);
      wr(OFF_IRQ_MASK, 16'h0001);
      for (int i = 0; i < 5; i++)
         convert(src_tab[i], lo_tab[i], hi_tab[i]);
      // RC clock while the device sleeps
      rc_run <= 1'b1;
      sleep_mode <= 1'b1;
      wr(OFF_CONTROL_THREE, 16'h0380);
      convert(TRIG_AUTO, 125, 150);
      {rc_run, sleep_mode} <= 2'b00;
      wr(OFF_CONTROL_THREE, 16'h0109);
      // Abort in mid-conversion keeps the written result
      wr(OFF_RESULT, 16'h0abc);
      wr(OFF_IRQ_MASK, 16'h0002);
      wr(OFF_CONTROL_ONE, {8'h00, TRIG_AUTO, 5'h00});
      wr(OFF_CONTROL_ONE, {8'h80, TRIG_AUTO, 5'h04});
      repeat (60) @(posedge clk);
      wr(OFF_CONTROL_ONE, 16'h0000);
      repeat (300) @(posedge clk);
      rd(OFF_RESULT, d);
      chk(d, 16'h0abc);
      rd(OFF_IRQ_STATUS, d);
      chk(d, 16'h0002);
      chk({15'h0000, irq}, 16'h0001);
      wr(OFF_IRQ_MASK, 16'h0001);
      #1 chk({15'h0000, irq}, 16'h0000);
      wr(OFF_IRQ_STATUS, 16'h0002);
      wr(OFF_IRQ_MASK, 16'h0002);
      #1 chk({15'h0000, irq}, 16'h0000);
      report_and_stop();
   end
   // Watchdog
   initial
   begin
      #3000000;
      fail_count++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      report_and_stop();
   end
endmodule
`default_nettype wire
